// ===== design/sac_ctrl.sv
// conversion sequencer and host data port of a 16-bit sar converter
`timescale 1ns/100ps
`include "sac_consts.svh"

// ==================================================
// Overview of operation
// - a launched conversion always completes; strobe and power-down cannot abort it
// - at conversion end the output code is formed and busy drops
// - low-power mode: strobe held low with busy low self-launches next conversion
// - self-launch only in low-power mode; other modes need a strobe edge
// - self-launched rate is not clamped to the low-power throughput figure
// - low-power mode drops core power after each conversion; interface stays up
// - chip select or read strobe high puts the data outputs in high impedance; busy stays driven
// - coding select picks straight binary or twos complement for every result
// - overrange gives all ones, or largest positive in twos complement
// - underrange gives all zeros, or most negative in twos complement
// - port style low: result on parallel bus until the next result forms
// - byte order low: low byte on lower lane; high swaps the lanes
// - serial port shares the data pins, chosen by port style high
// - serial result leaves msb first, 16 shift clock pulses
// - each serial bit holds across both edges of its clock pulse
// - clock source low: device makes shift clock and frame strobe
// - shift clock and frame strobe polarity are each invertible
// - read timing input picks read after conversion or during next one
// - master read-after mode keeps busy high until all 16 bits are out
module sac_ctrl
    import sac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic convert_strobe_n,
    input wire logic power_down_in,
    input wire logic output_coding_sel,
    input wire logic port_style_sel,
    input wire logic byte_order_sel,
    input wire logic clock_source_sel,
    input wire logic read_timing_chain_in,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic overRange,
    input wire logic underRange,
    input wire logic [15:0] sampleCode,
    output logic busy,
    output logic [15:0] dataOut,
    output logic dataOe_n,
    output logic corePowerSave
);

    localparam logic [9:0] CONV_FAST_CYC = 10'(`SAC_NS2CYC(`SAC_CONV_FAST_NS));
    localparam logic [9:0] CONV_NORM_CYC = 10'(`SAC_NS2CYC(`SAC_CONV_NORM_NS));
    localparam logic [9:0] CONV_LOWP_CYC = 10'(`SAC_NS2CYC(`SAC_CONV_LOWP_NS));
    localparam logic [9:0] ACQ_CYC = 10'(`SAC_NS2CYC(`SAC_ACQ_NS));
    localparam logic [2:0] QTR_CYC = 3'(`SAC_QTR_CYC);

    // ==================================================
    // pin synchroniser
    logic [`SAC_PIN_W-1:0] pinRaw;
    logic [`SAC_PIN_W-1:0] pinMeta;
    logic [`SAC_PIN_W-1:0] pinSync;
    sac_pins_s pin;
    logic cnvPrev;
    logic cnvFall;

    assign pinRaw = {convert_strobe_n, power_down_in, output_coding_sel, port_style_sel,
                     byte_order_sel, clock_source_sel, read_timing_chain_in, chip_select_n,
                     read_strobe_n, overRange, underRange, sampleCode};
    assign pin = sac_pins_s'(pinSync);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= `SAC_PIN_RST;
            pinSync <= `SAC_PIN_RST;
        end else begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnvPrev <= 1'b1;
        end else begin
            cnvPrev <= pin.cnvN;
        end
    end

    assign cnvFall = cnvPrev & ~pin.cnvN;

    // ==================================================
    // wishbone slave
    sac_ctrl_s ctrl;
    sac_state_e state;
    logic wbReq;
    logic [31:0] next_rdata;
    logic busyReg;
    logic resultValid;
    logic shiftActive;
    logic [15:0] result;

    assign wbReq = wb_cyc_i & wb_stb_i;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wbReq & ~wb_ack_o;
        end
    end

    // write lands on the edge where the master sees ack
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= sac_ctrl_s'(`SAC_CTRL_RST);
        end else if (wbReq & wb_ack_o & wb_we_i & wb_sel_i[0] && wb_adr_i == `SAC_ADR_CTRL) begin
            ctrl <= sac_ctrl_s'(wb_dat_i[`SAC_CTRL_W-1:0]);
        end
    end

    always_comb begin
        case (wb_adr_i)
            `SAC_ADR_CTRL: next_rdata = {27'h0, ctrl};
            `SAC_ADR_STATUS: next_rdata = {26'h0, corePowerSave, resultValid, shiftActive, state, busyReg};
            `SAC_ADR_RESULT: next_rdata = {16'h0, result};
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0;
        end else if (wbReq & ~wb_ack_o) begin
            wb_dat_o <= next_rdata;
        end
    end

    // ==================================================
    // output coding
    function automatic logic [15:0] codeOf(input logic [15:0] raw, input logic over,
                                          input logic under, input logic binary);
        logic [15:0] clip;
        clip = over ? `SAC_CODE_FULL : (under ? `SAC_CODE_ZERO : raw);
        codeOf = binary ? clip : clip ^ `SAC_CODE_MSB;
    endfunction

    // ==================================================
    // conversion sequencer
    logic lowPwr;
    logic masterSer;
    logic afterMode;
    logic autoNext;
    logic convStart;
    logic convEnd;
    logic shiftStart;
    logic [9:0] convCyc;
    logic [9:0] cnt;
    logic [15:0] heldCode;
    logic heldOver;
    logic heldUnder;
    logic [15:0] coded;

    assign lowPwr = ctrl.mode == SAC_MODE_LOWPWR;
    assign masterSer = pin.portSer & ~pin.clkExt;
    assign afterMode = pin.rdc == ctrl.rdcAfterHigh;
    assign autoNext = lowPwr & ~pin.cnvN;
    assign coded = codeOf(heldCode, heldOver, heldUnder, pin.coding);
    // first launch always needs a strobe edge, in low-power mode too
    assign convStart = (state == SAC_ST_IDLE && cnvFall && !pin.pd) ||
                       (state == SAC_ST_ACQ && autoNext && cnt == 10'h0);
    assign convEnd = state == SAC_ST_CONV && cnt == 10'h0;
    assign shiftStart = masterSer & ~shiftActive &
                        ((convEnd & afterMode) | (convStart & ~afterMode & resultValid));

    always_comb begin
        case (ctrl.mode)
            SAC_MODE_FAST: convCyc = CONV_FAST_CYC;
            SAC_MODE_LOWPWR: convCyc = CONV_LOWP_CYC;
            default: convCyc = CONV_NORM_CYC;
        endcase
    end

    // power-down and strobe are only looked at outside a conversion
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SAC_ST_IDLE;
            cnt <= 10'h0;
            busyReg <= 1'b0;
        end else begin
            case (state)
                SAC_ST_IDLE: begin
                    if (convStart) begin
                        state <= SAC_ST_CONV;
                        cnt <= convCyc - 10'h1;
                        busyReg <= 1'b1;
                    end
                end
                SAC_ST_CONV: begin
                    if (cnt != 10'h0) begin
                        cnt <= cnt - 10'h1;
                    end else if (masterSer & afterMode) begin
                        state <= SAC_ST_SHIFT;
                    end else begin
                        busyReg <= 1'b0;
                        cnt <= ACQ_CYC - 10'h1;
                        state <= autoNext ? SAC_ST_ACQ : SAC_ST_IDLE;
                    end
                end
                SAC_ST_SHIFT: begin
                    if (!shiftActive) begin
                        busyReg <= 1'b0;
                        cnt <= ACQ_CYC - 10'h1;
                        state <= autoNext ? SAC_ST_ACQ : SAC_ST_IDLE;
                    end
                end
                SAC_ST_ACQ: begin
                    // acquisition runs from busy falling, input must already be settled
                    // no throughput clamp: relaunch as soon as acquisition ends
                    if (!autoNext) begin
                        state <= SAC_ST_IDLE;
                    end else if (cnt != 10'h0) begin
                        cnt <= cnt - 10'h1;
                    end else begin
                        state <= SAC_ST_CONV;
                        cnt <= convCyc - 10'h1;
                        busyReg <= 1'b1;
                    end
                end
                default: begin
                    state <= SAC_ST_IDLE;
                    busyReg <= 1'b0;
                end
            endcase
        end
    end

    // sample taken at the start of conversion, result formed at its end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            heldCode <= 16'h0;
            heldOver <= 1'b0;
            heldUnder <= 1'b0;
        end else if (convStart) begin
            heldCode <= pin.code;
            heldOver <= pin.over;
            heldUnder <= pin.under;
        end
    end

    // result stands through the next acquisition and following conversion
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= 16'h0;
            resultValid <= 1'b0;
        end else if (convEnd) begin
            result <= coded;
            resultValid <= 1'b1;
        end
    end

    // ==================================================
    // master serial shifter: each bit is four quarters, clock high in the middle
    // two, so data is steady across both clock edges
    logic [15:0] shiftReg;
    logic [3:0] bitCnt;
    logic [1:0] qtr;
    logic [2:0] divCnt;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shiftActive <= 1'b0;
            shiftReg <= 16'h0;
            bitCnt <= 4'h0;
            qtr <= 2'h0;
            divCnt <= 3'h0;
        end else if (!shiftActive) begin
            if (shiftStart) begin
                shiftActive <= 1'b1;
                shiftReg <= afterMode ? coded : result;
                bitCnt <= 4'h0;
                qtr <= 2'h0;
                divCnt <= QTR_CYC - 3'h1;
            end
        end else if (divCnt != 3'h0) begin
            divCnt <= divCnt - 3'h1;
        end else begin
            divCnt <= QTR_CYC - 3'h1;
            qtr <= qtr + 2'h1;
            if (qtr == 2'h3) begin
                shiftReg <= {shiftReg[14:0], 1'b0};
                bitCnt <= bitCnt + 4'h1;
                if (bitCnt == 4'hf) begin
                    shiftActive <= 1'b0;
                end
            end
        end
    end

    // ==================================================
    // pin drivers
    logic [15:0] next_data;
    logic sclkRaw;

    assign sclkRaw = shiftActive && (qtr == 2'h1 || qtr == 2'h2);

    always_comb begin
        next_data = 16'h0;
        if (pin.portSer) begin
            // slave clocking is not built: only the master port drives the shared pins
            if (masterSer) begin
                next_data[`SAC_SDO_BIT] = shiftActive & shiftReg[15];
                next_data[`SAC_SCLK_BIT] = sclkRaw ^ ctrl.sclkInv;
                next_data[`SAC_SYNC_BIT] = shiftActive ^ ctrl.syncInv;
            end
        end else if (pin.swap) begin
            next_data = {result[7:0], result[15:8]};
        end else begin
            next_data = result;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataOut <= 16'h0;
            dataOe_n <= 1'b1;
            busy <= 1'b0;
            corePowerSave <= 1'b0;
        end else begin
            dataOut <= next_data;
            dataOe_n <= pin.csN | pin.rdN;
            busy <= busyReg;
            // reads during conversion should finish early; nothing here enforces it
            corePowerSave <= lowPwr && (state == SAC_ST_IDLE || state == SAC_ST_ACQ);
        end
    end

endmodule // sac_ctrl

// ===== design/sac_consts.svh
// constants of the sar converter sequencer: offsets, fields, resets, timing
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// ==================================================
// register map (byte addresses)
`define SAC_ADR_CTRL 8'h00
`define SAC_ADR_STATUS 8'h04
`define SAC_ADR_RESULT 8'h08
`define SAC_CTRL_RST 5'h00
`define SAC_CTRL_W 5

// ==================================================
// shared data pins used by the serial port
`define SAC_SDO_BIT 0
`define SAC_SCLK_BIT 1
`define SAC_SYNC_BIT 2

// ==================================================
// codes
`define SAC_CODE_FULL 16'hffff
`define SAC_CODE_ZERO 16'h0000
`define SAC_CODE_MSB 16'h8000

// ==================================================
// timing
`define SAC_CLK_MHZ 250
`define SAC_CONV_FAST_NS 750
`define SAC_CONV_NORM_NS 1000
`define SAC_CONV_LOWP_NS 1250
`define SAC_ACQ_NS 250
`define SAC_NS2CYC(ns) (((ns) * `SAC_CLK_MHZ + 999) / 1000)
`define SAC_QTR_CYC 2

// ==================================================
// pin synchroniser reset: convert and read strobes and chip select idle high, other selects low
`define SAC_PIN_W 27
`define SAC_PIN_RST 27'h40c0000

`endif

// ===== design/sac_pkg.sv
// types of the sar converter sequencer
package sac_pkg;

    typedef enum logic [1:0] {
        SAC_MODE_FAST = 2'b00,
        SAC_MODE_NORMAL = 2'b01,
        SAC_MODE_LOWPWR = 2'b10
    } sac_mode_e;

    typedef enum logic [1:0] {
        SAC_ST_IDLE = 2'b00,
        SAC_ST_CONV = 2'b01,
        SAC_ST_SHIFT = 2'b10,
        SAC_ST_ACQ = 2'b11
    } sac_state_e;

    typedef struct packed {
        logic rdcAfterHigh;
        logic syncInv;
        logic sclkInv;
        sac_mode_e mode;
    } sac_ctrl_s;

    typedef struct packed {
        logic cnvN;
        logic pd;
        logic coding;
        logic portSer;
        logic swap;
        logic clkExt;
        logic rdc;
        logic csN;
        logic rdN;
        logic over;
        logic under;
        logic [15:0] code;
    } sac_pins_s;

endpackage

// ===== dv/sac_ctrl_asserts.sv
// port checks of the conversion sequencer
`timescale 1ns/100ps
module sac_ctrl_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic convert_strobe_n,
    input wire logic power_down_in,
    input wire logic port_style_sel,
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic busy,
    input wire logic [15:0] dataOut,
    input wire logic dataOe_n,
    input wire logic corePowerSave
);
    // =====
    // busy length; fast mode is the shortest conversion
    int busyLen;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busyLen <= 0;
        end else begin
            busyLen <= busy ? busyLen + 1 : 0;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_off; (chip_select_n || read_strobe_n) [*4]; endsequence
    sequence s_launch; $fell(convert_strobe_n) && !busy && !power_down_in; endsequence
    property p_ackNext; s_req |=> wb_ack_o; endproperty
    property p_ackOnce; wb_ack_o |=> !wb_ack_o; endproperty
    property p_ackCause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_hiZ; s_off |-> dataOe_n; endproperty
    property p_launch; s_launch |-> ##[1:8] busy; endproperty
    property p_noAbort; $fell(busy) |-> busyLen >= 188; endproperty
    property p_serHold;
        port_style_sel && $past(port_style_sel, 4) && !dataOe_n && $changed(dataOut[1]) |-> $stable(dataOut[0]);
    endproperty
    property p_pwrUp; busy && $past(busy) && $past(busy, 2) |-> !corePowerSave; endproperty
    a_ackNext: assert property (p_ackNext) else $error("ack missing");
    a_ackOnce: assert property (p_ackOnce) else $error("ack too long");
    a_ackCause: assert property (p_ackCause) else $error("ack without request");
    a_hiZ: assert property (p_hiZ) else $error("bus driven while deselected");
    a_launch: assert property (p_launch) else $error("no conversion after strobe");
    a_noAbort: assert property (p_noAbort) else $error("conversion cut short");
    a_serHold: assert property (p_serHold) else $error("serial bit moved at clock edge");
    a_pwrUp: assert property (p_pwrUp) else $error("power save while converting");
endmodule // sac_ctrl_asserts

bind sac_ctrl sac_ctrl_asserts u_chk (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .convert_strobe_n,
    .power_down_in, .port_style_sel, .chip_select_n, .read_strobe_n, .busy, .dataOut, .dataOe_n, .corePowerSave);

// ===== dv/sac_host_model.sv
// host receiving master serial frames
`timescale 1ns/100ps
module sac_host_model (
    input wire logic sys_clk,
    input wire logic [15:0] dataOut,
    input wire logic dataOe_n,
    input wire logic sclkInv,
    input wire logic syncInv,
    output logic [15:0] word,
    output int frames
);
    logic lastClk = 1'b0;
    logic [15:0] shiftIn = '0;
    int bits = 0;
    initial word = '0;
    initial frames = 0;
    // takes the bit on the true rising edge only, so data must hold there
    always @(posedge sys_clk) begin
        lastClk <= dataOut[1] ^ sclkInv;
        if (dataOe_n || !(dataOut[2] ^ syncInv)) begin
            bits <= 0;
        end else if ((dataOut[1] ^ sclkInv) && !lastClk) begin
            shiftIn <= {shiftIn[14:0], dataOut[0]};
            bits <= bits + 1;
            if (bits == 15) begin
                word <= {shiftIn[14:0], dataOut[0]};
                frames <= frames + 1;
            end
        end
    end
endmodule // sac_host_model

// ===== dv/sac_ctrl_bench.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/100ps
module sac_ctrl_bench;
    logic sys_clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o;
    logic [3:0] wb_sel_i = '0;
    logic wb_ack_o, busy, dataOe_n, corePowerSave, inv = 1'b0;
    logic [15:0] dataOut, word, sampleCode = '0;
    logic convert_strobe_n = 1'b1, power_down_in = 1'b0, output_coding_sel = 1'b1, port_style_sel = 1'b0;
    logic byte_order_sel = 1'b0, clock_source_sel = 1'b0, read_timing_chain_in = 1'b0;
    logic chip_select_n = 1'b0, read_strobe_n = 1'b0, overRange = 1'b0, underRange = 1'b0;
    int mismatches = 0, compares = 0, frames;
    always #2 sys_clk = ~sys_clk;
    sac_ctrl dut (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_dat_o, .wb_ack_o, .convert_strobe_n, .power_down_in, .output_coding_sel, .port_style_sel,
        .byte_order_sel, .clock_source_sel, .read_timing_chain_in, .chip_select_n, .read_strobe_n,
        .overRange, .underRange, .sampleCode, .busy, .dataOut, .dataOe_n, .corePowerSave);
    sac_host_model host (.sys_clk, .dataOut, .dataOe_n, .sclkInv(inv), .syncInv(inv), .word, .frames);
    // =====
    // tasks
    task automatic wrap_up();
        if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 50) mismatches++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic convert(output int width);
        int n;
        n = 0;
        width = 0;
        convert_strobe_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        convert_strobe_n <= 1'b1;
        while (busy !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        // strobe and power-down while busy must not restart it
        convert_strobe_n <= 1'b0;
        power_down_in <= 1'b1;
        @(posedge sys_clk);
        convert_strobe_n <= 1'b1;
        power_down_in <= 1'b0;
        while (busy === 1'b1 && width < 2000) begin
            @(posedge sys_clk);
            width++;
        end
        if (n >= 20 || width >= 2000) mismatches++;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        logic [31:0] rd;
        logic [15:0] exp;
        int w, rises;
        logic prevBusy, saw;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        wb(1'b0, 8'h00, 32'h0, rd);
        chk(rd, 32'h0);
        wb(1'b1, 8'h00, 32'h15, rd);
        wb(1'b0, 8'h00, 32'h0, rd);
        chk(rd, 32'h15);
        wb(1'b1, 8'h40, 32'hff, rd);
        wb(1'b0, 8'h40, 32'h0, rd);
        chk(rd, 32'h0);
        wb(1'b1, 8'h00, 32'h0, rd);
        // =====
        // parallel codes: plain, coded and swapped, over and under range
        for (int i = 0; i < 6; i++) begin
            overRange <= (i == 2 || i == 3);
            underRange <= (i >= 4);
            output_coding_sel <= ~i[0];
            byte_order_sel <= (i == 1);
            sampleCode <= 16'h1234;
            exp = (i == 2 || i == 3) ? 16'hffff : (i >= 4 ? 16'h0000 : 16'h1234);
            if (i[0]) exp = exp ^ 16'h8000;
            if (i == 1) exp = {exp[7:0], exp[15:8]};
            @(posedge sys_clk);
            convert(w);
            repeat (4) @(posedge sys_clk);
            chk(dataOut, exp);
            chk(dataOe_n, 1'b0);
            read_strobe_n <= 1'b1;
            repeat (5) @(posedge sys_clk);
            chk(dataOe_n, 1'b1);
            read_strobe_n <= 1'b0;
        end
        // host reads the previous result early in a running conversion
        convert_strobe_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        convert_strobe_n <= 1'b1;
        chk(busy, 1'b1);
        chk(dataOut, 16'h8000);
        repeat (300) @(posedge sys_clk);
        // =====
        // strobe held low: low-power chains conversions, fast mode does one
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, 8'h00, m ? 32'h0 : 32'h2, rd);
            rises = 0;
            saw = 1'b0;
            prevBusy = 1'b0;
            convert_strobe_n <= 1'b0;
            repeat (1200) begin
                @(posedge sys_clk);
                if (busy === 1'b1 && !prevBusy) rises++;
                prevBusy = busy;
                if (corePowerSave === 1'b1) saw = 1'b1;
            end
            convert_strobe_n <= 1'b1;
            repeat (700) @(posedge sys_clk);
            chk(m ? rises == 1 : rises >= 3, 1'b1);
            chk(saw, !m);
        end
        // =====
        // master serial, read after then read during conversion
        port_style_sel <= 1'b1;
        read_timing_chain_in <= 1'b1;
        sampleCode <= 16'ha5c3;
        output_coding_sel <= 1'b1;
        byte_order_sel <= 1'b0;
        underRange <= 1'b0;
        wb(1'b1, 8'h00, 32'h10, rd);
        convert(w);
        repeat (4) @(posedge sys_clk);
        chk(w > 300, 1'b1);
        chk(word, 16'ha5c3);
        inv <= 1'b1;
        read_timing_chain_in <= 1'b0;
        sampleCode <= 16'h5a3c;
        wb(1'b1, 8'h00, 32'h1c, rd);
        convert(w);
        repeat (4) @(posedge sys_clk);
        chk(w < 300, 1'b1);
        chk(word, 16'ha5c3);
        sampleCode <= 16'h0f0f;
        @(posedge sys_clk);
        convert(w);
        repeat (4) @(posedge sys_clk);
        chk(word, 16'h5a3c);
        chk(frames, 3);
        wrap_up();
    end
endmodule // sac_ctrl_bench
